/* File: rtl/dct_pkg.sv */
`default_nettype none
package dct_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0]  DCT_OFS_CKE_EXIT = 8'h00;
  localparam logic [7:0]  DCT_OFS_CKE_LOW  = 8'h04;
  localparam logic [7:0]  DCT_OFS_PHY_LAT  = 8'h08;
  localparam logic [7:0]  DCT_OFS_MODE_SET = 8'h0c;
  localparam logic [7:0]  DCT_OFS_CTRL     = 8'h10;
  localparam logic [7:0]  DCT_OFS_STATUS   = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int          DCT_CKEH_LSB     = 0;
  localparam int          DCT_CKEH_W       = 8;
  localparam int          DCT_CKEL_LSB     = 0;
  localparam int          DCT_CKEL_W       = 4;
  localparam int          DCT_RDLAT_LSB    = 16;
  localparam int          DCT_RDLAT_W      = 6;
  localparam int          DCT_WRLAT_LSB    = 0;
  localparam int          DCT_WRLAT_W      = 4;
  localparam int          DCT_MODE_SET_TO_COMMAND_COUNT_LSB     = 16;
  localparam int          DCT_MODE_SET_TO_COMMAND_COUNT_W       = 6;
  localparam int          DCT_READ_TO_MODE_SET_COUNT_LSB    = 0;
  localparam int          DCT_READ_TO_MODE_SET_COUNT_W      = 6;
  localparam int          DCT_CTRL_ACC_BIT = 0;
  localparam int          DCT_CTRL_REF_BIT = 1;
  localparam int          DCT_CTRL_MPR_BIT = 2;
  localparam int          DCT_ST_CKE_BIT   = 0;
  localparam int          DCT_ST_PD_BIT    = 1;
  localparam int          DCT_ST_LATOK_BIT = 2;
  localparam int          DCT_CNT_W        = 8;

  // ----------------------------------------------------------------
  // Writable-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] DCT_MASK_CKE_EXIT = 32'h0000_00ff;
  localparam logic [31:0] DCT_MASK_CKE_LOW  = 32'h0000_000f;
  localparam logic [31:0] DCT_MASK_PHY_LAT  = 32'h003f_000f;
  localparam logic [31:0] DCT_MASK_MODE_SET = 32'h003f_003f;
  localparam logic [31:0] DCT_MASK_CTRL     = 32'h0000_0007;
  localparam logic [31:0] DCT_TIMING_RST    = 32'h0000_0000;
  localparam logic [2:0]  DCT_CTRL_RST      = 3'h0;

  // Only legal latency settings for the memory PHY
  localparam logic [5:0]  DCT_RDLAT_ONLY    = 6'h16;
  localparam logic [3:0]  DCT_WRLAT_ONLY    = 4'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DCT_CMD_READ     = 3'h0,
    DCT_CMD_WRITE    = 3'h1,
    DCT_CMD_MRS      = 3'h2,
    DCT_CMD_OTHER    = 3'h3,
    DCT_CMD_PD_ENTER = 3'h4,
    DCT_CMD_PD_EXIT  = 3'h5
  } dct_cmd_kind_t;

  typedef struct packed {
    logic          valid;
    dct_cmd_kind_t kind;
  } dct_cmd_t;

  typedef struct packed {
    logic [5:0] read_data_latency;
    logic [3:0] write_data_latency;
  } dct_phy_cfg_t;

  typedef enum logic [1:0] {
    DCT_ST_AWAKE = 2'b01,
    DCT_ST_PDOWN = 2'b10
  } dct_state_t;

endpackage
`default_nettype wire

/* File: rtl/dct_cmd_timing.sv */
`timescale 1ns/10ps
`default_nettype none

module dct_cmd_timing (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  sys_resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [3:0]            activate_to_read_delay,
  input  wire dct_pkg::dct_cmd_t     cmd_req,
  output logic                       cmd_ready,
  output dct_pkg::dct_cmd_t          mem_cmd,
  output logic                       cke,
  output dct_pkg::dct_phy_cfg_t      phy_cfg,
  output logic                       refresh_reload
);
  import dct_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]          cke_exit_timing;
    logic [31:0]          cke_low_timing;
    logic [31:0]          phy_data_latency;
    logic [31:0]          mode_set_timing;
    logic [2:0]           ctrl;
    dct_state_t           fsm;
    logic [DCT_CNT_W-1:0] since_cke;
    logic [DCT_CNT_W-1:0] since_mrs;
    logic [DCT_CNT_W-1:0] since_read;
    logic [31:0]          prdata;
    dct_cmd_t             mem_cmd;
    logic                 refresh_reload;
  } dct_regs_t;

  localparam logic [DCT_CNT_W-1:0] CNT_SAT = {DCT_CNT_W{1'b1}};

  dct_regs_t st_q;
  dct_regs_t st_d;
  logic      ready_c;
  logic      err_c;

  function automatic logic [DCT_CNT_W-1:0] sat_inc(input logic [DCT_CNT_W-1:0] v);
    sat_inc = (v == CNT_SAT) ? v : v + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]           ckeh;
    logic [3:0]           ckel;
    logic [5:0]           mode_set_to_command_count;
    logic [5:0]           read_to_mode_set_count;
    logic [8:0]           rd_gap;
    logic                 locked;
    logic                 hit;
    logic                 is_timing;
    logic                 gap_ok;
    logic [31:0]          rd_mux;
    ckeh      = 8'h00;
    ckel      = 4'h0;
    mode_set_to_command_count      = 6'h00;
    read_to_mode_set_count     = 6'h00;
    rd_gap    = 9'h000;
    locked    = 1'b0;
    hit       = 1'b0;
    is_timing = 1'b0;
    gap_ok    = 1'b0;
    rd_mux    = 32'h0000_0000;
    st_d      = st_q;
    ready_c   = 1'b0;
    err_c     = 1'b0;

    ckeh  = st_q.cke_exit_timing[DCT_CKEH_LSB +: DCT_CKEH_W];
    ckel  = st_q.cke_low_timing[DCT_CKEL_LSB +: DCT_CKEL_W];
    mode_set_to_command_count  = st_q.mode_set_timing[DCT_MODE_SET_TO_COMMAND_COUNT_LSB +: DCT_MODE_SET_TO_COMMAND_COUNT_W];
    read_to_mode_set_count = st_q.mode_set_timing[DCT_READ_TO_MODE_SET_COUNT_LSB +: DCT_READ_TO_MODE_SET_COUNT_W];
    rd_gap = {1'b0, ckeh} + {5'h00, activate_to_read_delay};

    st_d.mem_cmd.valid  = 1'b0;
    st_d.refresh_reload = 1'b0;
    // Counters tick once per pclk, which is the memory clock here
    st_d.since_cke  = sat_inc(st_q.since_cke);
    st_d.since_mrs  = sat_inc(st_q.since_mrs);
    st_d.since_read = sat_inc(st_q.since_read);

    // --------------------------------------------------------------
    // Command gating
    // --------------------------------------------------------------
    gap_ok = ({1'b0, st_q.since_cke} >= {1'b0, ckeh}) &&
             ({2'b00, st_q.since_mrs} >= {2'b00, mode_set_to_command_count});
    unique case (st_q.fsm)
      DCT_ST_AWAKE: begin
        unique case (cmd_req.kind)
          DCT_CMD_READ: begin
            ready_c = gap_ok && ({1'b0, st_q.since_cke} >= rd_gap);
          end
          DCT_CMD_MRS: begin
            ready_c = gap_ok && (!st_q.ctrl[DCT_CTRL_MPR_BIT] ||
                      ({2'b00, st_q.since_read} >= {2'b00, read_to_mode_set_count}));
          end
          DCT_CMD_WRITE, DCT_CMD_OTHER, DCT_CMD_PD_ENTER: begin
            ready_c = gap_ok;
          end
          default: begin
            ready_c = 1'b0;
          end
        endcase
      end
      DCT_ST_PDOWN: begin
        // Only an exit is meaningful while CKE is low
        ready_c = (cmd_req.kind == DCT_CMD_PD_EXIT) &&
                  ({4'h0, st_q.since_cke} >= {8'h00, ckel});
      end
      default: begin
        ready_c = 1'b0;
      end
    endcase
    // No memory traffic until software opens access
    ready_c = ready_c && st_q.ctrl[DCT_CTRL_ACC_BIT];

    if (cmd_req.valid && ready_c) begin
      st_d.mem_cmd.valid = 1'b1;
      st_d.mem_cmd.kind  = cmd_req.kind;
      unique case (cmd_req.kind)
        DCT_CMD_READ: begin
          st_d.since_read = {{(DCT_CNT_W-1){1'b0}}, 1'b1};
        end
        DCT_CMD_MRS: begin
          st_d.since_mrs = {{(DCT_CNT_W-1){1'b0}}, 1'b1};
        end
        DCT_CMD_PD_ENTER: begin
          st_d.fsm       = DCT_ST_PDOWN;
          st_d.since_cke = {{(DCT_CNT_W-1){1'b0}}, 1'b1};
        end
        DCT_CMD_PD_EXIT: begin
          st_d.fsm       = DCT_ST_AWAKE;
          st_d.since_cke = {{(DCT_CNT_W-1){1'b0}}, 1'b1};
        end
        default: begin
        end
      endcase
    end

    // --------------------------------------------------------------
    // APB slave
    // --------------------------------------------------------------
    locked = st_q.ctrl[DCT_CTRL_ACC_BIT] | st_q.ctrl[DCT_CTRL_REF_BIT];
    unique case (paddr)
      DCT_OFS_CKE_EXIT: begin
        hit = 1'b1;
        is_timing = 1'b1;
        rd_mux = st_q.cke_exit_timing;
      end
      DCT_OFS_CKE_LOW: begin
        hit = 1'b1;
        is_timing = 1'b1;
        rd_mux = st_q.cke_low_timing;
      end
      DCT_OFS_PHY_LAT: begin
        hit = 1'b1;
        is_timing = 1'b1;
        rd_mux = st_q.phy_data_latency;
      end
      DCT_OFS_MODE_SET: begin
        hit = 1'b1;
        is_timing = 1'b1;
        rd_mux = st_q.mode_set_timing;
      end
      DCT_OFS_CTRL: begin
        hit = 1'b1;
        rd_mux = {29'h0000_0000, st_q.ctrl};
      end
      DCT_OFS_STATUS: begin
        hit = 1'b1;
        rd_mux[DCT_ST_CKE_BIT] = (st_q.fsm == DCT_ST_AWAKE);
        rd_mux[DCT_ST_PD_BIT]  = (st_q.fsm == DCT_ST_PDOWN);
        rd_mux[DCT_ST_LATOK_BIT] =
          (st_q.phy_data_latency[DCT_RDLAT_LSB +: DCT_RDLAT_W] == DCT_RDLAT_ONLY) &&
          (st_q.phy_data_latency[DCT_WRLAT_LSB +: DCT_WRLAT_W] == DCT_WRLAT_ONLY);
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    // Read data is captured in the setup cycle so prdata is a flop
    if (psel && !penable) begin
      st_d.prdata = rd_mux;
    end

    // Timing writes with access or refresh live are refused, not applied
    err_c = psel && penable && (!hit || (pwrite && is_timing && locked));

    if (psel && penable && pwrite && !err_c) begin
      unique case (paddr)
        DCT_OFS_CKE_EXIT: st_d.cke_exit_timing  = pwdata & DCT_MASK_CKE_EXIT;
        DCT_OFS_CKE_LOW:  st_d.cke_low_timing   = pwdata & DCT_MASK_CKE_LOW;
        DCT_OFS_PHY_LAT:  st_d.phy_data_latency = pwdata & DCT_MASK_PHY_LAT;
        DCT_OFS_MODE_SET: st_d.mode_set_timing  = pwdata & DCT_MASK_MODE_SET;
        DCT_OFS_CTRL: begin
          st_d.ctrl = pwdata[2:0] & DCT_MASK_CTRL[2:0];
          st_d.refresh_reload = pwdata[DCT_CTRL_REF_BIT];
        end
        default: begin
        end
      endcase
    end

    // System reset restarts control but keeps programmed timings
    if (!sys_resetn) begin
      st_d.ctrl           = DCT_CTRL_RST;
      st_d.fsm            = DCT_ST_AWAKE;
      st_d.since_cke      = CNT_SAT;
      st_d.since_mrs      = CNT_SAT;
      st_d.since_read     = CNT_SAT;
      st_d.mem_cmd.valid  = 1'b0;
      st_d.refresh_reload = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register; presetn is the power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.cke_exit_timing  <= DCT_TIMING_RST;
      st_q.cke_low_timing   <= DCT_TIMING_RST;
      st_q.phy_data_latency <= DCT_TIMING_RST;
      st_q.mode_set_timing  <= DCT_TIMING_RST;
      st_q.ctrl             <= DCT_CTRL_RST;
      st_q.fsm              <= DCT_ST_AWAKE;
      st_q.since_cke        <= CNT_SAT;
      st_q.since_mrs        <= CNT_SAT;
      st_q.since_read       <= CNT_SAT;
      st_q.prdata           <= 32'h0000_0000;
      st_q.mem_cmd          <= '{valid: 1'b0, kind: DCT_CMD_OTHER};
      st_q.refresh_reload   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata         = st_q.prdata;
  assign pready         = 1'b1;
  assign pslverr        = err_c;
  assign cmd_ready      = ready_c;
  assign mem_cmd        = st_q.mem_cmd;
  assign cke            = (st_q.fsm == DCT_ST_AWAKE);
  assign refresh_reload = st_q.refresh_reload;
  assign phy_cfg.read_data_latency  =
    st_q.phy_data_latency[DCT_RDLAT_LSB +: DCT_RDLAT_W];
  assign phy_cfg.write_data_latency =
    st_q.phy_data_latency[DCT_WRLAT_LSB +: DCT_WRLAT_W];

endmodule

`default_nettype wire

/* File: sim/dct_cmd_timing_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module dct_cmd_timing_monitor (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  sys_resetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [3:0]            activate_to_read_delay,
  input wire dct_pkg::dct_cmd_t     cmd_req,
  input wire logic                  cmd_ready,
  input wire dct_pkg::dct_cmd_t     mem_cmd,
  input wire logic                  cke,
  input wire dct_pkg::dct_phy_cfg_t phy_cfg,
  input wire logic                  refresh_reload
);
  import dct_pkg::*;
  logic       wr;
  logic       cke_q;
  logic [7:0] hi_q, sc_q, sm_q, sr_q, lc_q;
  logic [3:0] lo_q;
  logic [5:0] tm_q, rm_q;
  logic [9:0] ph_q;
  logic [2:0] ct_q;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction
  // ------------------------------------------------------------
  // Shadows of accepted writes
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= '0;
      lo_q <= '0;
      ph_q <= '0;
      tm_q <= '0;
      rm_q <= '0;
      ct_q <= '0;
    end else if (!sys_resetn) begin
      ct_q <= '0;
    end else if (wr) begin
      if (paddr == DCT_OFS_CKE_EXIT) hi_q <= pwdata[7:0];
      if (paddr == DCT_OFS_CKE_LOW) lo_q <= pwdata[3:0];
      if (paddr == DCT_OFS_PHY_LAT) ph_q <= {pwdata[21:16], pwdata[3:0]};
      if (paddr == DCT_OFS_MODE_SET) tm_q <= pwdata[21:16];
      if (paddr == DCT_OFS_MODE_SET) rm_q <= pwdata[5:0];
      if (paddr == DCT_OFS_CTRL) ct_q <= pwdata[2:0];
    end
  end
  // Wake, mode-set and read gaps saturate on either reset, as the controller's own counters do; the low count clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_q  <= '1;
      sm_q  <= '1;
      sr_q  <= '1;
      lc_q  <= '0;
      cke_q <= 1'b1;
    end else if (!sys_resetn) begin
      sc_q  <= '1;
      sm_q  <= '1;
      sr_q  <= '1;
      lc_q  <= '0;
      cke_q <= 1'b1;
    end else begin
      cke_q <= cke;
      sc_q  <= (cke && !cke_q) ? 8'h01 : inc(sc_q);
      sm_q  <= (mem_cmd.valid && mem_cmd.kind == DCT_CMD_MRS) ? 8'h01 : inc(sm_q);
      sr_q  <= (mem_cmd.valid && mem_cmd.kind == DCT_CMD_READ) ? 8'h01 : inc(sr_q);
      lc_q  <= cke ? 8'h00 : inc(lc_q);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !sys_resetn);
  property p_accept;
    cmd_req.valid && cmd_ready |=> mem_cmd.valid && mem_cmd.kind == $past(cmd_req.kind);
  endproperty
  a_accept: assert property (p_accept) else $error("accepted command not issued");
  property p_high;
    mem_cmd.valid && mem_cmd.kind != DCT_CMD_PD_EXIT |-> sc_q >= hi_q;
  endproperty
  a_high: assert property (p_high) else $error("command too soon after wake");
  property p_read;
    mem_cmd.valid && mem_cmd.kind == DCT_CMD_READ |-> sc_q >= hi_q + activate_to_read_delay;
  endproperty
  a_read: assert property (p_read) else $error("read too soon after wake");
  property p_low;
    $rose(cke) |-> lc_q >= 8'(lo_q);
  endproperty
  a_low: assert property (p_low) else $error("clock enable low too short");
  property p_phy;
    phy_cfg == ph_q;
  endproperty
  a_phy: assert property (p_phy) else $error("latency outputs wrong");
  property p_mod;
    mem_cmd.valid |-> sm_q >= tm_q;
  endproperty
  a_mod: assert property (p_mod) else $error("command too soon after mode set");
  property p_mpr;
    mem_cmd.valid && mem_cmd.kind == DCT_CMD_MRS && ct_q[DCT_CTRL_MPR_BIT] |-> sr_q >= rm_q;
  endproperty
  a_mpr: assert property (p_mpr) else $error("mode set too soon after read");
  property p_lock;
    psel && penable && pwrite && paddr <= DCT_OFS_MODE_SET && ct_q[1:0] != 2'b00 |-> pslverr;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write not refused");
  property p_rd;
    psel && penable && !pwrite && paddr == DCT_OFS_CKE_EXIT |-> prdata == {24'h0, hi_q};
  endproperty
  a_rd: assert property (p_rd) else $error("read value wrong");
  property p_reload;
    wr && paddr == DCT_OFS_CTRL && pwdata[DCT_CTRL_REF_BIT] |=> refresh_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload pulse");
  c_mrs: cover property (mem_cmd.valid && mem_cmd.kind == DCT_CMD_MRS);
  c_wake: cover property ($rose(cke));
  c_err: cover property (psel && penable && pslverr);
endmodule
bind dct_cmd_timing dct_cmd_timing_monitor u_mon (
  .pclk, .presetn, .sys_resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .activate_to_read_delay, .cmd_req, .cmd_ready, .mem_cmd, .cke, .phy_cfg,
  .refresh_reload
);
`default_nettype wire

/* File: sim/dct_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dct_mem_model (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              cke,
  input wire dct_pkg::dct_cmd_t mem_cmd,
  output logic                  bad_q,
  output logic [7:0]            seen_q
);
  import dct_pkg::*;
  // A device with CKE low only takes the power-down entry; any other command would be lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_q <= 1'b0;
      seen_q <= '0;
    end else if (mem_cmd.valid) begin
      seen_q <= seen_q + 8'h01;
      if (!cke && mem_cmd.kind != DCT_CMD_PD_ENTER) bad_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/dct_cmd_timing_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module dct_cmd_timing_bench;
  import dct_pkg::*;
  localparam logic [7:0]  ADR [4] = '{DCT_OFS_CKE_EXIT, DCT_OFS_CKE_LOW, DCT_OFS_PHY_LAT,
                                      DCT_OFS_MODE_SET};
  localparam logic [31:0] WV [4] = '{32'hffff_ff03, 32'hffff_fff6, 32'hffd6_fff2, 32'hffc4_ffc7};
  localparam logic [31:0] EV [4] = '{32'h3, 32'h6, 32'h0016_0002, 32'h0004_0007};
  logic         pclk, presetn, sys_resetn, psel, penable, pwrite, pready, pslverr, e;
  logic         cmd_ready, cke, refresh_reload, bad;
  logic [7:0]   paddr, seen;
  logic [31:0]  pwdata, prdata, r;
  logic [3:0]   activate_to_read_delay;
  dct_cmd_t     cmd_req, mem_cmd;
  dct_phy_cfg_t phy_cfg;
  int           err_count, tests_run, g;
  dct_cmd_timing u_dut (.pclk, .presetn, .sys_resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .activate_to_read_delay, .cmd_req, .cmd_ready,
    .mem_cmd, .cke, .phy_cfg, .refresh_reload);
  dct_mem_model u_mem (.pclk, .presetn, .cke, .mem_cmd, .bad_q(bad), .seen_q(seen));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // g counts edges from the previous acceptance to this one
  task automatic issue(input dct_cmd_kind_t k);
    g = 2;
    @(posedge pclk);
    cmd_req <= '{valid: 1'b1, kind: k};
    @(negedge pclk);
    while (cmd_ready !== 1'b1) begin
      @(negedge pclk);
      g++;
    end
    @(posedge pclk);
    cmd_req <= '0;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    sys_resetn = 1'b1;
    activate_to_read_delay = 4'h2;
    cmd_req = '0;
    err_count = 0;
    tests_run = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ADR[i], '0);
      chk(r, '0);
      apb(1'b1, ADR[i], WV[i]);
      apb(1'b0, ADR[i], '0);
      chk(r, EV[i]);
    end
    chk(phy_cfg, {DCT_RDLAT_ONLY, DCT_WRLAT_ONLY});
    apb(1'b0, DCT_OFS_STATUS, '0);
    chk(r, 32'h5);
    apb(1'b0, 8'h18, '0);
    chk(r, '0);
    chk(e, 1'b1);
    apb(1'b1, DCT_OFS_CTRL, 32'h7);
    @(negedge pclk);
    chk(refresh_reload, 1'b1);
    apb(1'b1, DCT_OFS_CKE_EXIT, 32'h9);
    chk(e, 1'b1);
    apb(1'b0, DCT_OFS_CKE_EXIT, '0);
    chk(r, 32'h3);
    issue(DCT_CMD_MRS);
    issue(DCT_CMD_OTHER);
    chk(g, 4);
    for (int i = 0; i < 2; i++) begin
      issue(DCT_CMD_PD_ENTER);
      issue(DCT_CMD_PD_EXIT);
      chk(g, 6);
      issue(i ? DCT_CMD_READ : DCT_CMD_WRITE);
      chk(g, i ? 5 : 3);
    end
    issue(DCT_CMD_MRS);
    chk(g, 7);
    repeat (2) @(negedge pclk);
    chk({cke, bad, seen}, {2'b10, 8'd9});
    @(posedge pclk);
    sys_resetn <= 1'b0;
    repeat (2) @(posedge pclk);
    sys_resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ADR[i], '0);
      chk(r, EV[i]);
    end
    apb(1'b0, DCT_OFS_CTRL, '0);
    chk(r, '0);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DCT_OFS_MODE_SET, '0);
    chk(r, '0);
    wrap_up();
  end
endmodule
`default_nettype wire
